// ==== src/aor_defines.svh ====
// Purpose: Offsets, field positions, codes and reset values for routing select
// Assumes: Register indices as printed; byte address is four times the index
// Notes:   Definitions only
`ifndef AOR_DEFINES_SVH
`define AOR_DEFINES_SVH
`define AOR_RATE_IDX0   16'hf140
`define AOR_SRC_IDX0    16'hf180
`define AOR_STAT_IDX    16'hf1f0
`define AOR_NUM_CONV    16'h0008
`define AOR_NUM_PAIR    16'h0018
`define AOR_SRC_BASE    5'h08
`define AOR_MEM_DEPTH   32
`define AOR_REG_RESET   16'h0000
`define AOR_FIFO_DEPTH  8
`define AOR_WORD_W      24
`define AOR_F_RATE      23
`define AOR_F_IDX       18
`define AOR_F_CLS       15
`define AOR_F_SUB       12
`define AOR_F_OCH       6
`define AOR_F_PORT      4
`define AOR_F_CCH       0
`define AOR_RC_NONE     4'h0
`define AOR_RC_SOUT0    4'h1
`define AOR_RC_SOUT3    4'h4
`define AOR_RC_DSP      4'h5
`define AOR_RC_G1       4'h6
`define AOR_RC_G1X2     4'h7
`define AOR_RC_G1X4     4'h8
`define AOR_RC_G1D2     4'h9
`define AOR_RC_G2D3     4'ha
`define AOR_RC_G1D4     4'hb
`define AOR_RC_G2D6     4'hc
`define AOR_SC_OFF      3'h0
`define AOR_SC_CONV     3'h3
`define AOR_SC_PDM23    3'h5
`define AOR_PAIR_PORT1  5'h08
`define AOR_PAIR_PORT2  5'h10
`define AOR_PAIR_PORT3  5'h14
`endif

// ==== src/aor_pkg.sv ====
// Purpose: Types shared by the routing select block
// Assumes: Nothing
// Notes:   Enum order fixes the class and scale codes in route words
package aor_pkg;
  typedef enum logic [2:0] {
    RCL_NONE, RCL_SOUT, RCL_DSP, RCL_GEN1, RCL_GEN2
  } aor_rate_cls_t;
  typedef enum logic [2:0] {
    G1_X1, G1_X2, G1_X4, G1_D2, G1_D4
  } aor_gen1_scale_t;
  typedef enum logic [2:0] {G2_D3, G2_D6} aor_gen2_scale_t;
  typedef enum logic [1:0] {ST_IDLE, ST_RDHOLD} aor_apb_state_t;
endpackage

// ==== src/aor_reg_mem.sv ====
// Purpose: Register storage, one write port and a registered read port
// Assumes: Synchronous active-low reset clears every word
// Notes:   Read data follow the read address by one cycle
`timescale 1ns/100ps
`default_nettype none
`include "aor_defines.svh"
module aor_reg_mem
  import aor_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        wrEn,
  input  wire logic [4:0]  wrAddr,
  input  wire logic [15:0] wrData,
  input  wire logic [4:0]  rdAddr,
  output var  logic [15:0] rdData
);
  logic [15:0] word_ff [`AOR_MEM_DEPTH];
  logic [15:0] rdData_ff;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      for (int i = 0; i < `AOR_MEM_DEPTH; i++) begin
        word_ff[i] <= `AOR_REG_RESET;
      end
      rdData_ff <= `AOR_REG_RESET;
    end else begin
      if (wrEn) begin
        word_ff[wrAddr] <= wrData;
      end
      rdData_ff <= word_ff[rdAddr];
    end
  end

  assign rdData = rdData_ff;
endmodule
`default_nettype wire

// ==== src/aor_fifo.sv ====
// Purpose: Small synchronous FIFO with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes:   Output word comes straight from the storage flops
`timescale 1ns/100ps
`default_nettype none
module aor_fifo
  import aor_pkg::*;
#(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
) (
  input  wire logic                       clk,
  input  wire logic                       rstn,
  input  wire logic                       inValid,
  output logic                            inReady,
  input  wire logic [WIDTH-1:0]           inData,
  output logic                            outValid,
  input  wire logic                       outReady,
  output logic [WIDTH-1:0]                outData,
  output logic [$clog2(DEPTH):0]          level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] store_ff [DEPTH];
  logic [AW-1:0]    wrPtr_ff, nxt_wrPtr;
  logic [AW-1:0]    rdPtr_ff, nxt_rdPtr;
  logic [AW:0]      cnt_ff, nxt_cnt;
  logic             push, pop;

  assign inReady  = (cnt_ff != (AW+1)'(DEPTH));
  assign outValid = (cnt_ff != '0);
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;
  assign outData  = store_ff[rdPtr_ff];
  assign level    = cnt_ff;

  always_comb begin
    nxt_wrPtr = push ? AW'(wrPtr_ff + 1'b1) : wrPtr_ff;
    nxt_rdPtr = pop ? AW'(rdPtr_ff + 1'b1) : rdPtr_ff;
    nxt_cnt   = cnt_ff;
    if (push && !pop) begin
      nxt_cnt = (AW+1)'(cnt_ff + 1'b1);
    end else if (pop && !push) begin
      nxt_cnt = (AW+1)'(cnt_ff - 1'b1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
      cnt_ff   <= '0;
    end else begin
      wrPtr_ff <= nxt_wrPtr;
      rdPtr_ff <= nxt_rdPtr;
      cnt_ff   <= nxt_cnt;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      store_ff[wrPtr_ff] <= inData;
    end
  end
endmodule
`default_nettype wire

// ==== src/aor_routing_select.sv ====
// Purpose: APB register bank for converter rate and output pair source select
// Assumes: APB master on clk (40 MHz); byte address = register index * 4
// Notes:   Each accepted write emits a decoded route word through a FIFO
//
// What this block does
// - 4-bit rate field per converter, bits 3..0; reset zero means none.
// - Codes 1 to 4 lock converter output to serial output port 0..3.
// - Code 5 locks converter output to the DSP core sample rate.
// - Code 6 selects the first generator's base rate.
// - Codes 7 and 8 select twice and four times first generator rate.
// - Codes 9 and 11 select half and quarter of first generator rate.
// - Codes 10 and 12 select second generator one-third and one-sixth.
// - Eight rate registers in a row; register k serves channels 2k, 2k+1.
// - 24 source registers in a row; register n drives channels 2n, 2n+1.
// - Registers 0-7 feed output port 0, 8-15 feed port 1.
// - Registers 16-19 feed output port 2, 20-23 feed port 3.
// - 3-bit source: off, serial input, DSP, converter, mic 0-1, mic 2-3.
// - Converter choice in bits 5..3 counts only when source is 011.
// - Choice k routes converter channels 2k and 2k+1 to the pair.
//
// Chosen here: the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "aor_defines.svh"
module aor_routing_select
  import aor_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rstn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [17:0]            paddr,
  input  wire logic [31:0]            pwdata,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  output logic                        routeValid,
  input  wire logic                   routeReady,
  output logic [`AOR_WORD_W-1:0]      routeWord
);
  // Map an index to {stored, status, storage slot}
  function automatic logic [6:0] aorMap(input logic [15:0] idx);
    logic [15:0] r;
    logic [15:0] s;
    r = idx - `AOR_RATE_IDX0;
    s = idx - `AOR_SRC_IDX0;
    aorMap = 7'h00;
    if (r < `AOR_NUM_CONV) begin
      aorMap = {2'b10, r[4:0]};
    end else if (s < `AOR_NUM_PAIR) begin
      aorMap = {2'b10, 5'(s[4:0] + `AOR_SRC_BASE)};
    end else if (idx == `AOR_STAT_IDX) begin
      aorMap = 7'h20;
    end
  endfunction

  function automatic logic [`AOR_WORD_W-1:0] rateDesc(
    input logic [3:0] code,
    input logic [2:0] k
  );
    aor_rate_cls_t cls;
    logic [2:0]    sub;
    cls = RCL_NONE;
    sub = 3'h0;
    case (code)
      `AOR_RC_SOUT0, 4'h2, 4'h3, `AOR_RC_SOUT3: begin
        cls = RCL_SOUT;
        sub = 3'(code - `AOR_RC_SOUT0);
      end
      `AOR_RC_DSP: cls = RCL_DSP;
      `AOR_RC_G1: begin
        cls = RCL_GEN1;
        sub = G1_X1;
      end
      `AOR_RC_G1X2: begin
        cls = RCL_GEN1;
        sub = G1_X2;
      end
      `AOR_RC_G1X4: begin
        cls = RCL_GEN1;
        sub = G1_X4;
      end
      `AOR_RC_G1D2: begin
        cls = RCL_GEN1;
        sub = G1_D2;
      end
      `AOR_RC_G1D4: begin
        cls = RCL_GEN1;
        sub = G1_D4;
      end
      `AOR_RC_G2D3: begin
        cls = RCL_GEN2;
        sub = 3'(G2_D3);
      end
      `AOR_RC_G2D6: begin
        cls = RCL_GEN2;
        sub = 3'(G2_D6);
      end
      default: cls = RCL_NONE;
    endcase
    rateDesc = {1'b1, {2'b00, k}, cls, sub, 6'h00, 2'b00, {k, 1'b0}};
  endfunction

  function automatic logic [`AOR_WORD_W-1:0] srcDesc(
    input logic [5:0] val,
    input logic [4:0] n
  );
    logic [2:0] cls;
    logic [2:0] pick;
    logic [1:0] port;
    cls  = (val[2:0] > `AOR_SC_PDM23) ? `AOR_SC_OFF : val[2:0];
    pick = (cls == `AOR_SC_CONV) ? val[5:3] : 3'h0;
    if (n < `AOR_PAIR_PORT1) begin
      port = 2'h0;
    end else if (n < `AOR_PAIR_PORT2) begin
      port = 2'h1;
    end else if (n < `AOR_PAIR_PORT3) begin
      port = 2'h2;
    end else begin
      port = 2'h3;
    end
    srcDesc = {1'b0, n, cls, pick, {n, 1'b0}, port, {pick, 1'b0}};
  endfunction

  aor_apb_state_t state_ff, nxt_state;
  logic [31:0]    prdata_ff, nxt_prdata;
  logic           slverr_ff, nxt_slverr;
  logic [6:0]     hit;
  logic           memHit, statHit;
  logic [4:0]     slot;
  logic [4:0]     pairIdx;
  logic           access;
  logic           pushValid, fifoReady, memWe;
  logic [`AOR_WORD_W-1:0] pushWord;
  logic [15:0]    memRdata;
  logic [3:0]     level;

  assign hit     = aorMap(paddr[17:2]);
  assign memHit  = hit[6];
  assign statHit = hit[5];
  assign slot    = hit[4:0];
  assign pairIdx = 5'(slot - `AOR_SRC_BASE);
  assign access  = psel && penable;

  // Decoded from the write data so the word is ready in the access cycle
  assign pushWord = (slot < `AOR_SRC_BASE)
                    ? rateDesc(pwdata[3:0], slot[2:0])
                    : srcDesc(pwdata[5:0], pairIdx);
  assign pushValid = access && pwrite && memHit && (state_ff == ST_IDLE);
  assign memWe     = pushValid && fifoReady;

  // A full FIFO stalls the bus write instead of dropping a route word
  always_comb begin
    nxt_state  = state_ff;
    nxt_prdata = prdata_ff;
    nxt_slverr = slverr_ff;
    pready     = 1'b0;
    pslverr    = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (access && pwrite) begin
          pready  = memHit ? fifoReady : 1'b1;
          pslverr = !memHit;
        end else if (access) begin
          nxt_prdata = 32'h0000_0000;
          if (memHit) begin
            nxt_prdata = {16'h0000, memRdata};
          end else if (statHit) begin
            nxt_prdata = {26'h0, level, !fifoReady, !routeValid};
          end
          nxt_slverr = !(memHit || statHit);
          nxt_state  = ST_RDHOLD;
        end
      end
      ST_RDHOLD: begin
        pready    = 1'b1;
        pslverr   = slverr_ff;
        nxt_state = ST_IDLE;
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_ff  <= ST_IDLE;
      prdata_ff <= 32'h0000_0000;
      slverr_ff <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      prdata_ff <= nxt_prdata;
      slverr_ff <= nxt_slverr;
    end
  end

  assign prdata = prdata_ff;

  aor_reg_mem u_mem (
    .clk    (clk),
    .rstn   (rstn),
    .wrEn   (memWe),
    .wrAddr (slot),
    .wrData (pwdata[15:0]),
    .rdAddr (slot),
    .rdData (memRdata)
  );

  aor_fifo #(
    .WIDTH (`AOR_WORD_W),
    .DEPTH (`AOR_FIFO_DEPTH)
  ) u_fifo (
    .clk      (clk),
    .rstn     (rstn),
    .inValid  (pushValid),
    .inReady  (fifoReady),
    .inData   (pushWord),
    .outValid (routeValid),
    .outReady (routeReady),
    .outData  (routeWord),
    .level    (level)
  );

  // Checks on the pushed route words and the bus responses
  logic       isRate;
  logic [3:0] rc;
  logic [2:0] cls;
  logic [2:0] sub;
  assign isRate = pushWord[`AOR_F_RATE];
  assign rc     = pwdata[3:0];
  assign cls    = pushWord[`AOR_F_CLS +: 3];
  assign sub    = pushWord[`AOR_F_SUB +: 3];

  a_rate_none_zero: assert property (
    @(posedge clk) disable iff (!rstn)
    memWe && isRate && rc == `AOR_RC_NONE |-> cls == RCL_NONE)
    else $error("rate code zero not decoded as none");
  a_rate_sout_port: assert property (
    @(posedge clk) disable iff (!rstn)
    memWe && isRate && rc >= `AOR_RC_SOUT0 && rc <= `AOR_RC_SOUT3
    |-> cls == RCL_SOUT && sub == 3'(rc - 4'h1))
    else $error("serial port rate code misdecoded");
  a_rate_dsp_core: assert property (
    @(posedge clk) disable iff (!rstn)
    memWe && isRate && rc == `AOR_RC_DSP |-> cls == RCL_DSP)
    else $error("core rate code misdecoded");
  a_rate_gen_base: assert property (
    @(posedge clk) disable iff (!rstn)
    memWe && isRate && rc == `AOR_RC_G1 |-> cls == RCL_GEN1 && sub == G1_X1)
    else $error("base generator rate misdecoded");
  a_rate_gen_mult: assert property (
    @(posedge clk) disable iff (!rstn)
    memWe && isRate && (rc == `AOR_RC_G1X2 || rc == `AOR_RC_G1X4)
    |-> cls == RCL_GEN1 && sub == ((rc == `AOR_RC_G1X2) ? G1_X2 : G1_X4))
    else $error("generator multiple misdecoded");
  a_rate_gen_div: assert property (
    @(posedge clk) disable iff (!rstn)
    memWe && isRate && (rc == `AOR_RC_G1D2 || rc == `AOR_RC_G1D4)
    |-> cls == RCL_GEN1 && sub == ((rc == `AOR_RC_G1D2) ? G1_D2 : G1_D4))
    else $error("generator fraction misdecoded");
  a_rate_gen_two: assert property (
    @(posedge clk) disable iff (!rstn)
    memWe && isRate && (rc == `AOR_RC_G2D3 || rc == `AOR_RC_G2D6)
    |-> cls == RCL_GEN2 && sub[0] == (rc == `AOR_RC_G2D6))
    else $error("second generator rate misdecoded");
  a_rate_slot_out: assert property (
    @(posedge clk) disable iff (!rstn)
    memWe && isRate && !routeValid
    |-> pushWord[`AOR_F_CCH +: 4] == {paddr[4:2], 1'b0}
    ##1 routeValid && routeWord == $past(pushWord))
    else $error("rate word not delivered for its converter");
  a_rate_word_fields: assert property (
    @(posedge clk) disable iff (!rstn)
    memWe && isRate
    |-> pushWord[`AOR_F_IDX +: 5] == {2'b00, paddr[4:2]} &&
        pushWord[`AOR_F_OCH +: 6] == 6'h00 &&
        pushWord[`AOR_F_PORT +: 2] == 2'h0)
    else $error("rate word index or channel fields wrong");
  a_pair_index_ch: assert property (
    @(posedge clk) disable iff (!rstn)
    memWe && !isRate |-> pushWord[`AOR_F_IDX +: 5] == pairIdx &&
    pushWord[`AOR_F_OCH +: 6] == {pairIdx, 1'b0})
    else $error("pair index or channel wrong");
  a_pair_port_low: assert property (
    @(posedge clk) disable iff (!rstn)
    memWe && !isRate && pairIdx < `AOR_PAIR_PORT2
    |-> pushWord[`AOR_F_PORT +: 2] == {1'b0, pairIdx[3]})
    else $error("pair mapped to wrong low port");
  a_pair_port_high: assert property (
    @(posedge clk) disable iff (!rstn)
    memWe && !isRate && pairIdx >= `AOR_PAIR_PORT2
    |-> pushWord[`AOR_F_PORT +: 2] ==
        ((pairIdx < `AOR_PAIR_PORT3) ? 2'h2 : 2'h3))
    else $error("pair mapped to wrong high port");
  a_src_code_kept: assert property (
    @(posedge clk) disable iff (!rstn)
    memWe && !isRate && pwdata[2:0] <= `AOR_SC_PDM23 |-> cls == pwdata[2:0])
    else $error("source code misdecoded");
  a_src_code_undef: assert property (
    @(posedge clk) disable iff (!rstn)
    memWe && !isRate && pwdata[2:0] > `AOR_SC_PDM23 |-> cls == `AOR_SC_OFF)
    else $error("undefined source code not treated as off");
  a_conv_gate_off: assert property (
    @(posedge clk) disable iff (!rstn)
    memWe && !isRate && pwdata[2:0] != `AOR_SC_CONV |-> sub == 3'h0)
    else $error("converter choice leaked without converter source");
  a_conv_pick_pair: assert property (
    @(posedge clk) disable iff (!rstn)
    memWe && !isRate && pwdata[2:0] == `AOR_SC_CONV
    |-> sub == pwdata[5:3] &&
        pushWord[`AOR_F_CCH +: 4] == {pwdata[5:3], 1'b0})
    else $error("converter pair choice wrong");
  a_rate_undef_none: assert property (
    @(posedge clk) disable iff (!rstn)
    memWe && isRate && rc > `AOR_RC_G2D6 |-> cls == RCL_NONE)
    else $error("undefined rate code not treated as none");
  a_read_wait_one: assert property (
    @(posedge clk) disable iff (!rstn)
    access && !pwrite && state_ff == ST_IDLE |-> !pready ##1 pready)
    else $error("read did not answer after one wait state");
  a_read_high_zero: assert property (
    @(posedge clk) disable iff (!rstn)
    access && !pwrite && pready |-> prdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  a_unmapped_error: assert property (
    @(posedge clk) disable iff (!rstn)
    access && pready && !memHit && !statHit |-> pslverr)
    else $error("unmapped access answered without error");
  a_mapped_no_error: assert property (
    @(posedge clk) disable iff (!rstn)
    access && pready && memHit |-> !pslverr)
    else $error("register access answered with error");
  a_full_write_stall: assert property (
    @(posedge clk) disable iff (!rstn)
    access && pwrite && memHit && !fifoReady |-> !pready && !memWe)
    else $error("write accepted while route buffer full");
  a_stray_write_error: assert property (
    @(posedge clk) disable iff (!rstn)
    access && pwrite && !memHit |-> pready && pslverr && !pushValid)
    else $error("write outside register banks not refused");
  a_route_word_hold: assert property (
    @(posedge clk) disable iff (!rstn)
    routeValid && !routeReady |=> routeValid && $stable(routeWord))
    else $error("route word changed before it was taken");

  c_rate_write: cover property (@(posedge clk) disable iff (!rstn)
    memWe && isRate);
  c_conv_route: cover property (@(posedge clk) disable iff (!rstn)
    memWe && !isRate && cls == `AOR_SC_CONV);
  c_write_stall: cover property (@(posedge clk) disable iff (!rstn)
    pushValid && !fifoReady);
  c_read_back: cover property (@(posedge clk) disable iff (!rstn)
    state_ff == ST_RDHOLD && !slverr_ff);
  c_mic_route: cover property (@(posedge clk) disable iff (!rstn)
    memWe && !isRate && cls == `AOR_SC_PDM23);
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// Purpose: Self-checking bench for the routing select register bank
// Assumes: Bench is the APB master and the route word consumer
// Notes:   Expected route words are built here from the rate and source codes
`timescale 1ns/100ps
`default_nettype none
`include "aor_defines.svh"
module tb_top;
  logic                   clk;
  logic                   rstn;
  logic                   psel;
  logic                   penable;
  logic                   pwrite;
  logic [17:0]            paddr;
  logic [31:0]            pwdata;
  logic [31:0]            prdata;
  logic                   pready;
  logic                   pslverr;
  logic                   routeValid;
  logic                   routeReady;
  logic [`AOR_WORD_W-1:0] routeWord;
  logic [31:0]            rdVal;
  logic                   rdErr;
  int                     miscompares;
  int                     comparisons;
  // Class in [5:3], sub in [2:0]; undefined codes fall back to none
  localparam logic [5:0] RATE_MAP [16] = '{6'h00, 6'h08, 6'h09, 6'h0a,
    6'h0b, 6'h10, 6'h18, 6'h19, 6'h1a, 6'h1b, 6'h20, 6'h1c, 6'h21,
    6'h00, 6'h00, 6'h00};
  localparam logic [17:0] RATE_A = {`AOR_RATE_IDX0, 2'b00};
  localparam logic [17:0] SRC_A  = {`AOR_SRC_IDX0, 2'b00};

  aor_routing_select uut (
    .clk        (clk),
    .rstn       (rstn),
    .psel       (psel),
    .penable    (penable),
    .pwrite     (pwrite),
    .paddr      (paddr),
    .pwdata     (pwdata),
    .prdata     (prdata),
    .pready     (pready),
    .pslverr    (pslverr),
    .routeValid (routeValid),
    .routeReady (routeReady),
    .routeWord  (routeWord)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Request holds until pready is sampled high at a rising clock edge
  task automatic apb(input logic wr, input logic [17:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 200; i++) begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    check({31'h0, pready}, 32'h1);
    rdVal = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic pop(input logic [23:0] exp);
    int i;
    i = 0;
    do begin
      @(negedge clk);
      i++;
    end while (routeValid !== 1'b1 && i < 50);
    check({31'h0, routeValid}, 32'h1);
    check({8'h00, routeWord}, {8'h00, exp});
    @(posedge clk);
    routeReady <= 1'b1;
    @(posedge clk);
    routeReady <= 1'b0;
  endtask

  function automatic logic [23:0] rate_word(input int k, input int c);
    return {1'b1, 5'(k), RATE_MAP[c], 6'h00, 2'h0, 4'(2 * k)};
  endfunction

  function automatic logic [23:0] src_word(input int n, input int c,
                                           input int p);
    logic [2:0] cls;
    logic [1:0] port;
    logic       conv;
    cls = (c < 6) ? 3'(c) : 3'h0;
    conv = (cls == 3'h3);
    port = (n < 8) ? 2'd0 : (n < 16) ? 2'd1 : (n < 20) ? 2'd2 : 2'd3;
    return {1'b0, 5'(n), cls, conv ? 3'(p) : 3'h0, 6'(2 * n), port,
            conv ? 4'(2 * p) : 4'h0};
  endfunction

  task automatic t_reset;
    int i;
    for (i = 0; i < 32; i++) begin
      apb(1'b0, (i < 8) ? RATE_A + 18'(4 * i) : SRC_A + 18'(4 * i - 32),
          32'h0);
      check(rdVal, 32'h0);
    end
    $display("test reset values done");
  endtask

  // Every rate code, reserved bits set, upper bus half ignored
  task automatic t_rate;
    int c;
    logic [15:0] v;
    for (c = 0; c < 16; c++) begin
      v = {12'(12'h5a5 + c), 4'(c)};
      apb(1'b1, RATE_A + 18'(4 * (c % 8)), {16'hffff, v});
      check({31'h0, rdErr}, 32'h0);
      pop(rate_word(c % 8, c));
      apb(1'b0, RATE_A + 18'(4 * (c % 8)), 32'h0);
      check(rdVal, {16'h0, v});
    end
    $display("test rate codes done");
  endtask

  // Last eight passes walk every converter choice with source 011
  task automatic t_src;
    int i;
    int n;
    int c;
    logic [15:0] v;
    for (i = 0; i < 32; i++) begin
      n = i % 24;
      c = (i < 24) ? i % 8 : 3;
      v = {10'(10'h2c3 + i), 3'(i % 8), 3'(c)};
      apb(1'b1, SRC_A + 18'(4 * n), {16'ha5a5, v});
      pop(src_word(n, c, i % 8));
      apb(1'b0, SRC_A + 18'(4 * n), 32'h0);
      check(rdVal, {16'h0, v});
    end
    $display("test source codes done");
  endtask

  // Addresses just past each bank are unmapped and push nothing
  task automatic t_err;
    apb(1'b0, RATE_A + 18'h20, 32'h0);
    check({31'h0, rdErr}, 32'h1);
    check(rdVal, 32'h0);
    apb(1'b1, SRC_A + 18'h60, 32'h3);
    check({31'h0, rdErr}, 32'h1);
    apb(1'b1, {`AOR_STAT_IDX, 2'b00}, 32'h1);
    check({31'h0, rdErr}, 32'h1);
    repeat (3) @(negedge clk);
    check({31'h0, routeValid}, 32'h0);
    $display("test unmapped done");
  endtask

  // Fill the buffer, stall a ninth write, then drain in write order
  task automatic t_fifo;
    int i;
    for (i = 0; i < 8; i++)
      apb(1'b1, RATE_A + 18'(4 * i), 32'(i + 1));
    apb(1'b0, {`AOR_STAT_IDX, 2'b00}, 32'h0);
    check(rdVal, 32'h22);
    fork
      apb(1'b1, RATE_A, 32'h9);
      begin
        repeat (6) @(negedge clk);
        check({31'h0, pready}, 32'h0);
        pop(rate_word(0, 1));
      end
    join
    for (i = 1; i < 8; i++)
      pop(rate_word(i, i + 1));
    pop(rate_word(0, 9));
    @(negedge clk);
    check({31'h0, routeValid}, 32'h0);
    $display("test buffer full and drain done");
  endtask

  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 18'h0;
    pwdata = 32'h0;
    routeReady = 1'b0;
    miscompares = 0;
    comparisons = 0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    check({31'h0, routeValid}, 32'h0);
    t_reset;
    t_rate;
    t_src;
    t_err;
    t_fifo;
    stop_test;
  end

  // Whole run needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    stop_test;
  end
endmodule
`default_nettype wire
